/* File: dv/fieldbus_slave_poll_config_tb_top.sv */
// random and directed bench for the slave poll settings block
`default_nettype none
module fieldbus_slave_poll_config_tb_top
   import slave_poll_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = '0, rst_b = '0, awv = '0, wv = '0, bready = '0, arv = '0, rready = '0, mclr = '0, lost = '0;
   logic [7:0]  awa = '0, ara = '0;
   logic [31:0] wd = '0, resp = '0, seed = 32'h00016e6f, v, w, rdat, rxd;
   logic [15:0] dly = 16'h000b, wdp;
   logic [6:0]  sta = 7'h7e;
   logic        awr, wrdy, bv, arr, rv, irq, rxv;
   logic        b1ms = '0;
   logic [1:0]  br, rr;
   frame_s      frm, lf;
   control_s    ctl, lc;
   int          miscompares = 0, check_count = 0, nfr = 0, nctl = 0, gapc = 0, lgap = 0, n, c0;
   logic [15:0] cmds [4] = '{16'h0101, 16'h0201, 16'h1802, 16'hff03};
   slave_poll_config dut (.CORE_CLK(clk), .RST_B(rst_b), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
      .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy),
      .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bready), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
      .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rready),
      .MASTER_CLEAR(mclr), .LINK_LOST(lost), .RX_VALID(rxv), .RX_DATA(rxd), .TX_FRAME(frm),
      .TX_CONTROL(ctl), .WDOG_PARAM(wdp), .IRQ(irq));
   slave_dev_model peer (.clk(clk), .rst_b(rst_b), .frame(frm), .station(sta), .resp_dly(dly), .resp(resp),
      .wd_param(wdp), .wd_base1ms(b1ms), .rx_valid(rxv), .rx_data(rxd));
   always #5 clk = ~clk;
   always @(posedge clk) begin
      if (frm.valid) begin
         lf   <= frm;
         nfr  <= nfr + 1;
         lgap <= gapc;
         gapc <= 1;
      end else begin
         gapc <= gapc + 1;
      end
      if (ctl.valid) begin
         {lc, nctl} <= {ctl, nctl + 1};
      end
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [31:0] reord(input logic [1:0] m, input logic [31:0] d);
      return m == 2'h0 ? d : m == 2'h1 ? {d[23:16], d[31:24], d[7:0], d[15:8]}
         : m == 2'h2 ? {d[7:0], d[15:8], d[23:16], d[31:24]} : {d[15:0], d[31:16]};
   endfunction
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         miscompares++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
      logic ta;
      logic tw;
      ta = 1'b0;
      tw = 1'b0;
      @(posedge clk);
      {awa, wd, awv, wv} <= {a, d, 2'b11};
      while (!(ta && tw)) begin
         @(posedge clk);
         ta = ta || awr;
         tw = tw || wrdy;
         awv <= !ta;
         wv <= !tw;
      end
      // response left waiting a cycle so its hold is exercised
      repeat (2) @(posedge clk);
      bready <= 1'b1;
      do @(posedge clk); while (!bv);
      chk(br, e);
      bready <= 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge clk);
      {ara, arv} <= {a, 1'b1};
      do @(posedge clk); while (!arr);
      arv <= 1'b0;
      @(posedge clk);
      rready <= 1'b1;
      do @(posedge clk); while (!rv);
      chk(rr, er);
      chk(rdat, e);
      rready <= 1'b0;
   endtask
   task automatic wf(input int k);
      n = nfr + k;
      while (nfr < n) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic end_of_test;
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      #200us;
      miscompares++;
      end_of_test;
   end
   initial begin
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      rdc(OFF_ADDR, 32'(ADDR_RESET), 2'b00);
      rdc(OFF_TSDR, 32'(TSDR_MIN), 2'b00);
      rdc(OFF_INTERVAL, 32'(INTERVAL_MIN), 2'b00);
      rdc(OFF_WDOG, 32'(WDOG_DEFAULT), 2'b00);
      rdc(OFF_MODE, 32'h0, 2'b00);
      rdc(8'h3c, 32'h0, 2'b10);
      chk(wdp, 32'h0);
      wr(OFF_TSDR, 32'(TSDR_MAX), 2'b00);
      wr(OFF_TSDR, 32'h400, 2'b10);
      wr(OFF_TSDR, 32'h00a, 2'b10);
      rdc(OFF_TSDR, 32'(TSDR_MAX), 2'b00);
      wr(OFF_INTERVAL, 32'h0, 2'b10);
      wr(OFF_WDOG, 32'h96, 2'b00);
      rdc(OFF_WDOG, 32'(WDOG_DEFAULT), 2'b00);
      wr(OFF_WDOG, 32'h3e8, 2'b00);
      wr(OFF_MODE, 32'h10, 2'b00);
      wf(1);
      chk(wdp, 32'h3e8 / WD_BASE_LONG_MS);
      b1ms <= 1'b1;
      wr(OFF_MODE, 32'h50, 2'b00);
      wf(1);
      chk(wdp, 32'h3e8 / WD_BASE_SHORT_MS);
      $display("test limits done");
      b1ms <= 1'b0;
      wr(OFF_MODE, 32'hff00, 2'b00);
      rdc(OFF_MODE, 32'h0, 2'b00);
      wr(OFF_MODE, 32'h5a0c, 2'b00);
      rdc(OFF_MODE, 32'h5a0c, 2'b00);
      foreach (cmds[i]) begin
         c0 = nctl;
         wr(OFF_CMD, {16'h0, cmds[i]}, 2'b00);
         wf(1);
         chk(nctl - c0, |(cmds[i][15:8] & 8'h5a));
         if (nctl != c0) chk(lc, {1'b1, cmds[i][1:0], cmds[i][15:8] & 8'h5a});
      end
      $display("test groups done");
      for (int m = 0; m < 4; m++) begin
         v = rnd() % 126;
         w = rnd();
         sta <= v[6:0];
         resp <= rnd();
         dly <= 16'h000b + 16'(rnd() % 30);
         wr(OFF_ADDR, v, 2'b00);
         wr(OFF_OUT_DATA, w, 2'b00);
         wr(OFF_MODE, 32'(m), 2'b00);
         wf(2);
         chk(lf.addr, v);
         chk(lf.data, reord(m[1:0], w));
         repeat (50) @(posedge clk);
         rdc(OFF_IN_DATA, reord(m[1:0], resp), 2'b00);
      end
      wr(OFF_INTERVAL, 32'h3, 2'b00);
      wf(2);
      chk(lgap >= 300 && lgap <= 320, 1'b1);
      wr(OFF_INTERVAL, 32'h1, 2'b00);
      $display("test exchange done");
      wr(OFF_MODE, 32'h20, 2'b00);
      wr(OFF_IRQ_EN, 32'h2, 2'b00);
      lost <= 1'b1;
      repeat (4) @(negedge clk);
      chk(irq, 1'b1);
      rdc(OFF_IN_DATA, 32'h0, 2'b00);
      rdc(OFF_STATUS, 32'h7, 2'b00);
      lost <= 1'b0;
      wr(OFF_IRQ_CLR, 32'h2, 2'b00);
      repeat (3) @(negedge clk);
      chk(irq, 1'b0);
      wr(OFF_IRQ_EN, 32'h0, 2'b00);
      lost <= 1'b1;
      repeat (4) @(negedge clk);
      chk(irq, 1'b0);
      @(posedge clk);
      lost <= 1'b0;
      wr(OFF_MODE, 32'h80, 2'b00);
      mclr <= 1'b1;
      wf(2);
      chk({lf.clear, lf.zero_len}, 2'b11);
      wr(OFF_MODE, 32'h0, 2'b00);
      wf(2);
      chk({lf.clear, lf.zero_len}, 2'b10);
      chk(lf.data, 32'h0);
      $display("test loss and clear done");
      end_of_test;
   end
endmodule
`default_nettype wire

/* File: dv/slave_dev_model.sv */
// behavioural field slave answering exchange frames
`default_nettype none
module slave_dev_model
   import slave_poll_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   rst_b,
   input  wire slave_poll_pkg::frame_s frame,
   input  wire logic [6:0]             station,
   input  wire logic [15:0]            resp_dly,
   input  wire logic [31:0]            resp,
   input  wire logic [15:0]            wd_param,
   input  wire logic                   wd_base1ms,
   output var  logic                   rx_valid,
   output var  logic [31:0]            rx_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] cnt;
   logic        cfg;
   logic [63:0] idle;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt      <= 16'h0000;
         cfg      <= 1'b0;
         idle     <= 64'h0;
         rx_valid <= 1'b0;
         rx_data  <= 32'h0;
      end else begin
         rx_valid <= cnt == 16'h0001;
         rx_data  <= cnt == 16'h0001 ? resp : ~rx_data; // released line keeps toggling
         if (cnt != 16'h0000) cnt <= cnt - 16'h0001;
         idle <= idle + 64'h1;
         // silent past the watchdog time: back to unconfigured, 1 ms or 10 ms per unit
         if (wd_param != 16'h0 && idle >= 64'(wd_param) * (wd_base1ms ? 64'h186a0 : 64'hf4240)) begin
            cfg <= 1'b0;
         end
         if (frame.valid && frame.addr == station) begin
            idle <= 64'h0;
            cfg <= 1'b1;
            if (cfg) cnt <= resp_dly < 16'h000b ? 16'h000b : resp_dly;
         end
      end
   end
endmodule
`default_nettype wire

/* File: dv/slave_poll_chk.sv */
// assertions on the slave poll block outputs
`default_nettype none
module slave_poll_chk
   import slave_poll_pkg::*;
(
   input wire logic                     CORE_CLK,
   input wire logic                     RST_B,
   input wire logic                     S_AXI_BVALID,
   input wire logic                     S_AXI_BREADY,
   input wire logic [1:0]               S_AXI_BRESP,
   input wire logic                     S_AXI_RVALID,
   input wire logic                     S_AXI_RREADY,
   input wire logic [31:0]              S_AXI_RDATA,
   input wire slave_poll_pkg::frame_s   TX_FRAME,
   input wire slave_poll_pkg::control_s TX_CONTROL
);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RST_B);
   logic [15:0] gap;
   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) gap <= 16'hffff;
      else if (TX_FRAME.valid) gap <= 16'h0001;
      else if (gap != 16'hffff) gap <= gap + 16'h0001;
   end
   frame_gap_a: assert property (TX_FRAME.valid |-> gap >= US_CYCLES)
      else $error("frames too close");
   clear_data_a: assert property (TX_FRAME.valid && TX_FRAME.clear |-> TX_FRAME.zero_len || TX_FRAME.data == 32'h0)
      else $error("clear frame data not zero");
   empty_frame_a: assert property (TX_FRAME.valid && TX_FRAME.zero_len |-> TX_FRAME.clear)
      else $error("empty frame outside clear");
   ctrl_pulse_a: assert property (TX_CONTROL.valid |=> !TX_CONTROL.valid)
      else $error("control not a pulse");
   ctrl_groups_a: assert property (TX_CONTROL.valid |-> (TX_CONTROL.sync || TX_CONTROL.freeze) && |TX_CONTROL.groups)
      else $error("control without command or group");
   resp_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
      else $error("write response dropped");
   read_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
      else $error("read data dropped");
   resp_code_a: assert property (S_AXI_BVALID |-> S_AXI_BRESP == 2'b00 || S_AXI_BRESP == 2'b10)
      else $error("bad write response code");
endmodule
bind slave_poll_config slave_poll_chk u_chk (
   .CORE_CLK(CORE_CLK), .RST_B(RST_B), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
   .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
   .S_AXI_RDATA(S_AXI_RDATA), .TX_FRAME(TX_FRAME), .TX_CONTROL(TX_CONTROL));
`default_nettype wire

/* File: hdl/slave_poll_config.sv */
// per-slave poll settings, cyclic exchange pacing and data reorder with axi4-lite registers
// Notes on behaviour
// - Configured station address selects the slave addressed by every request frame.
// - Response delay register holds 11 to 1023 bit times, default 11.
// - At least the minimum interval in microseconds separates two exchanges.
// - Slave silent past watchdog resets itself; master must re-establish exchange.
// - Watchdog value never below the master-wide default, which is also reset.
// - Membership in up to 8 groups, one bit per group.
// - Sync or Freeze commands go out only for selected groups containing slave.
// - Group bits are writable only by a write that leaves Sync or Freeze mode enabled.
// - Freeze option is off after configuration is created.
// - Sync option is off by default.
// - Input and output bytes reordered: none, swap bytes, reverse, swap words.
// - With zero-on-failure set, lost link zeroes the held input data.
// - Watchdog parameter uses a 10 ms base unless the 1 ms base is chosen.
// - In clear state, fail-safe slaves get empty frames, others zero data.
`default_nettype none
module slave_poll_config
   import slave_poll_pkg::*;
#(
   parameter logic [15:0] WDOG_MIN = WDOG_DEFAULT
) (
   input  wire logic                  CORE_CLK,
   input  wire logic                  RST_B,
   input  wire logic [7:0]            S_AXI_AWADDR,
   input  wire logic                  S_AXI_AWVALID,
   output var  logic                  S_AXI_AWREADY,
   input  wire logic [31:0]           S_AXI_WDATA,
   input  wire logic [3:0]            S_AXI_WSTRB,
   input  wire logic                  S_AXI_WVALID,
   output var  logic                  S_AXI_WREADY,
   output var  logic [1:0]            S_AXI_BRESP,
   output var  logic                  S_AXI_BVALID,
   input  wire logic                  S_AXI_BREADY,
   input  wire logic [7:0]            S_AXI_ARADDR,
   input  wire logic                  S_AXI_ARVALID,
   output var  logic                  S_AXI_ARREADY,
   output var  logic [31:0]           S_AXI_RDATA,
   output var  logic [1:0]            S_AXI_RRESP,
   output var  logic                  S_AXI_RVALID,
   input  wire logic                  S_AXI_RREADY,
   input  wire logic                  MASTER_CLEAR,
   input  wire logic                  LINK_LOST,
   input  wire logic                  RX_VALID,
   input  wire logic [31:0]           RX_DATA,
   output var  slave_poll_pkg::frame_s   TX_FRAME,
   output var  slave_poll_pkg::control_s TX_CONTROL,
   output var  logic [15:0]           WDOG_PARAM,
   output var  logic                  IRQ
);
   import slave_poll_pkg::*;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        aw_held;
      logic [7:0]  aw_addr;
      logic        w_held;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic [6:0]  addr;
      logic [9:0]  tsdr;
      logic [15:0] interval;
      logic [15:0] wdog;
      logic [15:0] mode;
      logic [31:0] out_data;
      logic [31:0] in_data;
      logic [EV_WIDTH-1:0] status;
      logic [EV_WIDTH-1:0] irq_en;
      logic        exch_req;
      logic [6:0]  us_div;
      logic [15:0] us_left;
      frame_s      frame;
      control_s    control;
      logic [15:0] wdog_param;
      logic        irq;
   } state_s;

   state_s st;
   state_s next_st;

   function automatic logic [31:0] reorder(input logic [31:0] d, input swap_e s);
      logic [31:0] r;
      r = d;
      case (s)
         SWAP_BYTES:   r = {d[23:16], d[31:24], d[7:0], d[15:8]};
         SWAP_REVERSE: r = {d[7:0], d[15:8], d[23:16], d[31:24]};
         SWAP_WORDS:   r = {d[15:0], d[31:16]};
         default:      r = d;
      endcase
      return r;
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = d[i*8 +: 8];
         end
      end
      return r;
   endfunction

   logic [31:0] wval;
   logic [31:0] mode_w;
   logic [15:0] wd_cand;
   logic [EV_WIDTH-1:0] ev;
   logic        do_write;
   logic        do_read;
   logic        sync_cmd;
   logic        freeze_cmd;
   logic [7:0]  cmd_groups;
   swap_e       swap;

   always_comb begin
      next_st    = st;
      wval       = 32'h0;
      mode_w     = 32'h0;
      wd_cand    = 16'h0;
      ev         = '0;
      sync_cmd   = 1'b0;
      freeze_cmd = 1'b0;
      cmd_groups = 8'h0;
      swap       = swap_e'(st.mode[MODE_SWAP_LSB +: 2]);

      // write channel capture, either order
      next_st.awready = 1'b0;
      next_st.wready  = 1'b0;
      if (!st.aw_held && S_AXI_AWVALID && !st.awready) begin
         next_st.awready = 1'b1;
      end
      if (st.awready && S_AXI_AWVALID) begin
         next_st.aw_held = 1'b1;
         next_st.aw_addr = S_AXI_AWADDR;
      end
      if (!st.w_held && S_AXI_WVALID && !st.wready) begin
         next_st.wready = 1'b1;
      end
      if (st.wready && S_AXI_WVALID) begin
         next_st.w_held = 1'b1;
         next_st.w_data = S_AXI_WDATA;
         next_st.w_strb = S_AXI_WSTRB;
      end
      do_write = st.aw_held && st.w_held && !st.bvalid;
      if (st.bvalid && S_AXI_BREADY) begin
         next_st.bvalid = 1'b0;
      end

      if (do_write) begin
         next_st.aw_held = 1'b0;
         next_st.w_held  = 1'b0;
         next_st.bvalid  = 1'b1;
         next_st.bresp   = 2'b00;
         case (st.aw_addr)
            OFF_ADDR: begin
               wval = merge({25'h0, st.addr}, st.w_data, st.w_strb);
               next_st.addr = wval[6:0];
            end
            OFF_TSDR: begin
               wval = merge({22'h0, st.tsdr}, st.w_data, st.w_strb);
               if (wval[9:0] < TSDR_MIN || wval[31:10] != 22'h0) begin
                  next_st.bresp = 2'b10;
               end else begin
                  next_st.tsdr = wval[9:0];
               end
            end
            OFF_INTERVAL: begin
               wval = merge({16'h0, st.interval}, st.w_data, st.w_strb);
               if (wval[15:0] < INTERVAL_MIN) begin
                  next_st.bresp = 2'b10;
               end else begin
                  next_st.interval = wval[15:0];
               end
            end
            OFF_WDOG: begin
               wval    = merge({16'h0, st.wdog}, st.w_data, st.w_strb);
               wd_cand = wval[15:0];
               next_st.wdog = (wd_cand < WDOG_MIN) ? WDOG_MIN : wd_cand;
            end
            OFF_MODE: begin
               mode_w = merge({16'h0, st.mode}, st.w_data, st.w_strb);
               next_st.mode[7:0] = mode_w[7:0];
               if (mode_w[MODE_SYNC] || mode_w[MODE_FREEZE]) begin
                  next_st.mode[15:8] = mode_w[15:8];
               end
            end
            OFF_CMD: begin
               sync_cmd   = st.w_strb[0] && st.w_data[0];
               freeze_cmd = st.w_strb[0] && st.w_data[1];
               cmd_groups = st.w_data[15:8];
            end
            OFF_IRQ_EN: begin
               wval = merge({29'h0, st.irq_en}, st.w_data, st.w_strb);
               next_st.irq_en = wval[EV_WIDTH-1:0];
            end
            OFF_IRQ_CLR: begin
               next_st.status = st.status & ~(st.w_data[EV_WIDTH-1:0] & {EV_WIDTH{st.w_strb[0]}});
            end
            OFF_OUT_DATA: begin
               next_st.out_data = merge(st.out_data, st.w_data, st.w_strb);
            end
            default: begin
               next_st.bresp = 2'b10;
            end
         endcase
      end

      // read channel
      next_st.arready = 1'b0;
      do_read = st.arready && S_AXI_ARVALID;
      if (!st.rvalid && S_AXI_ARVALID && !st.arready) begin
         next_st.arready = 1'b1;
      end
      if (st.rvalid && S_AXI_RREADY) begin
         next_st.rvalid = 1'b0;
      end
      if (do_read) begin
         next_st.rvalid = 1'b1;
         next_st.rresp  = 2'b00;
         case (S_AXI_ARADDR)
            OFF_ADDR:     next_st.rdata = {25'h0, st.addr};
            OFF_TSDR:     next_st.rdata = {22'h0, st.tsdr};
            OFF_INTERVAL: next_st.rdata = {16'h0, st.interval};
            OFF_WDOG:     next_st.rdata = {16'h0, st.wdog};
            OFF_MODE:     next_st.rdata = {16'h0, st.mode};
            OFF_STATUS:   next_st.rdata = {29'h0, st.status};
            OFF_IRQ_EN:   next_st.rdata = {29'h0, st.irq_en};
            OFF_IN_DATA:  next_st.rdata = st.in_data;
            OFF_OUT_DATA: next_st.rdata = st.out_data;
            OFF_CMD, OFF_IRQ_CLR: next_st.rdata = 32'h0;
            default: begin
               next_st.rdata = 32'h0;
               next_st.rresp = 2'b10;
            end
         endcase
      end

      // control command to selected groups this slave belongs to
      next_st.control.valid = 1'b0;
      if ((sync_cmd && st.mode[MODE_SYNC]) || (freeze_cmd && st.mode[MODE_FREEZE])) begin
         if ((cmd_groups & st.mode[MODE_GRP_LSB +: 8]) != 8'h0) begin
            next_st.control.valid  = 1'b1;
            next_st.control.sync   = sync_cmd && st.mode[MODE_SYNC];
            next_st.control.freeze = freeze_cmd && st.mode[MODE_FREEZE];
            next_st.control.groups = cmd_groups & st.mode[MODE_GRP_LSB +: 8];
            ev[EV_CONTROL] = 1'b1;
         end
      end

      // exchange pacing in microseconds
      next_st.frame.valid = 1'b0;
      if (st.us_left != 16'h0) begin
         if (st.us_div == 7'(US_CYCLES - 1)) begin
            next_st.us_div  = 7'h0;
            next_st.us_left = st.us_left - 16'h1;
         end else begin
            next_st.us_div = st.us_div + 7'h1;
         end
      end else begin
         next_st.frame.valid = 1'b1;
         next_st.frame.addr  = st.addr;
         next_st.frame.clear = MASTER_CLEAR;
         next_st.frame.zero_len = MASTER_CLEAR && st.mode[MODE_FAILSAFE];
         next_st.frame.data  = MASTER_CLEAR ? 32'h0 : reorder(st.out_data, swap);
         next_st.us_div      = 7'h0;
         next_st.us_left     = st.interval;
         ev[EV_EXCHANGE]     = 1'b1;
      end

      // input data path
      if (LINK_LOST) begin
         ev[EV_LOST] = 1'b1;
         if (st.mode[MODE_ZERO]) begin
            next_st.in_data = 32'h0;
         end
      end else if (RX_VALID) begin
         next_st.in_data = reorder(RX_DATA, swap);
      end

      // watchdog parameter for the slave, which then supervises itself
      next_st.wdog_param = !st.mode[MODE_WDOG_EN] ? 16'h0 :
                           st.mode[MODE_BASE1MS] ? st.wdog / 16'(WD_BASE_SHORT_MS) :
                           st.wdog / 16'(WD_BASE_LONG_MS);

      next_st.status = next_st.status | ev;
      next_st.irq    = ((next_st.status & next_st.irq_en) != '0);
   end

   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         st          <= '0;
         st.addr     <= ADDR_RESET;
         st.tsdr     <= TSDR_MIN;
         st.interval <= INTERVAL_MIN;
         st.wdog     <= WDOG_DEFAULT;
         st.mode     <= 16'h0;
         st.us_left  <= INTERVAL_MIN;
      end else begin
         st <= next_st;
      end
   end

   assign S_AXI_AWREADY = st.awready;
   assign S_AXI_WREADY  = st.wready;
   assign S_AXI_BVALID  = st.bvalid;
   assign S_AXI_BRESP   = st.bresp;
   assign S_AXI_ARREADY = st.arready;
   assign S_AXI_RVALID  = st.rvalid;
   assign S_AXI_RDATA   = st.rdata;
   assign S_AXI_RRESP   = st.rresp;
   assign TX_FRAME      = st.frame;
   assign TX_CONTROL    = st.control;
   assign WDOG_PARAM    = st.wdog_param;
   assign IRQ           = st.irq;
endmodule
`default_nettype wire

/* File: hdl/slave_poll_pkg.sv */
// shared constants and types for the slave poll settings block
package slave_poll_pkg;
   localparam logic [7:0] OFF_ADDR     = 8'h00;
   localparam logic [7:0] OFF_TSDR     = 8'h04;
   localparam logic [7:0] OFF_INTERVAL = 8'h08;
   localparam logic [7:0] OFF_WDOG     = 8'h0c;
   localparam logic [7:0] OFF_MODE     = 8'h10;
   localparam logic [7:0] OFF_CMD      = 8'h14;
   localparam logic [7:0] OFF_STATUS   = 8'h18;
   localparam logic [7:0] OFF_IRQ_EN   = 8'h1c;
   localparam logic [7:0] OFF_IRQ_CLR  = 8'h20;
   localparam logic [7:0] OFF_IN_DATA  = 8'h24;
   localparam logic [7:0] OFF_OUT_DATA = 8'h28;

   localparam logic [9:0]  TSDR_MIN     = 10'h00b;
   localparam logic [9:0]  TSDR_MAX     = 10'h3ff;
   localparam logic [15:0] INTERVAL_MIN = 16'h0001;
   localparam logic [6:0]  ADDR_RESET   = 7'h7e;
   localparam logic [15:0] WDOG_DEFAULT = 16'h00c8;
   localparam int          CLK_MHZ      = 100;
   localparam int          US_CYCLES    = CLK_MHZ;
   localparam int          WD_BASE_LONG_MS  = 10;
   localparam int          WD_BASE_SHORT_MS = 1;

   localparam int MODE_SWAP_LSB = 0;
   localparam int MODE_FREEZE   = 2;
   localparam int MODE_SYNC     = 3;
   localparam int MODE_WDOG_EN  = 4;
   localparam int MODE_ZERO     = 5;
   localparam int MODE_BASE1MS  = 6;
   localparam int MODE_FAILSAFE = 7;
   localparam int MODE_GRP_LSB  = 8;

   localparam int EV_EXCHANGE = 0;
   localparam int EV_LOST     = 1;
   localparam int EV_CONTROL  = 2;
   localparam int EV_WIDTH    = 3;

   typedef enum logic [1:0] {SWAP_NONE, SWAP_BYTES, SWAP_REVERSE, SWAP_WORDS} swap_e;

   typedef struct packed {
      logic        valid;
      logic [6:0]  addr;
      logic        clear;
      logic        zero_len;
      logic [31:0] data;
   } frame_s;

   typedef struct packed {
      logic       valid;
      logic       freeze;
      logic       sync;
      logic [7:0] groups;
   } control_s;
endpackage
